// ===== dv/ptf_switch_model.sv
// external switch model: holds each pin level for at least HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module ptf_switch_model #(
  parameter int HOLD = 30
) (
  input wire logic clk,
  input wire logic [3:0] want,
  output logic [3:0] pins
);
  int age [4] = '{default: 0};
  initial pins = 4'hF;
  // a fast request is held back rather than dropped, so no glitch reaches the pins
  always @(negedge clk)
    for (int i = 0; i < 4; i++)
      if (want[i] !== pins[i] && age[i] >= HOLD)
      begin
        pins[i] <= want[i];
        age[i] <= 0;
      end
      else
        age[i] <= age[i] + 1;
endmodule : ptf_switch_model
`default_nettype wire

// ===== dv/ptf_trigger_props.sv
// port assertions for the trigger block
`timescale 1ns/1ps
`default_nettype none
module ptf_trigger_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] trig_mode,
  input wire logic alarm,
  input wire logic keypad_busy,
  input wire logic dir_load,
  input wire logic reciprocating_setting,
  input wire logic dual_pump_setting,
  input wire logic pumping,
  input wire logic pause_timer_active,
  input wire logic motor_option,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic prog_level,
  input wire logic lockout_level,
  input wire logic dir_infuse,
  input wire logic dir_out,
  input wire logic motor_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [3:0] m1_r;
  logic [3:0] m2_r;
  // a request may trail a mode change by one cycle; the check skips two
  wire mode_steady = trig_mode == m1_r && m1_r == m2_r;
  wire motor_want = pumping || motor_option && pause_timer_active;
  always_ff @(posedge clk)
  begin
    m1_r <= trig_mode;
    m2_r <= m1_r;
  end
  sequence s_blocked;
    (alarm || keypad_busy) [*3];
  endsequence
  a_start_no_stop: assert property (mode_steady && trig_mode inside {4'h4, 4'h5} |-> !stop_req)
    else $error("stop in start-only mode");
  a_stop_no_start: assert property (mode_steady && trig_mode inside {4'h6, 4'h7} |-> !start_req)
    else $error("start in stop-only mode");
  a_disabled_no_req: assert property (mode_steady && trig_mode >= 4'hC |-> !start_req && !stop_req)
    else $error("request while disabled");
  a_blocked_no_req: assert property (s_blocked |-> !start_req && !stop_req)
    else $error("request while blocked");
  // level modes request on every cycle the level holds, so only edge modes pulse
  a_req_one_cycle: assert property (mode_steady && trig_mode < 4'h8 && (start_req || stop_req) |=> !start_req && !stop_req)
    else $error("request longer than one cycle");
  a_motor_follows: assert property (!$past(rst) |-> motor_out == $past(motor_want))
    else $error("motor output wrong");
  a_dir_blocked: assert property ((alarm || keypad_busy) && !dir_load |=> $stable(dir_infuse))
    else $error("direction changed while blocked");
  a_dir_no_mode: assert property (!reciprocating_setting && !dual_pump_setting && !dir_load |=> $stable(dir_infuse))
    else $error("direction changed with no direction mode");
  a_dir_out_match: assert property (dir_out == dir_infuse)
    else $error("direction output differs");
  a_prog_lockout: assert property (prog_level == lockout_level)
    else $error("lockout level differs");
endmodule : ptf_trigger_props
`default_nettype wire

// ===== dv/pump_logic_io_trigger_filter_test.sv
// self-checking bench for the trigger block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("Error %0t %h %h", $time, a, e); end end
module pump_logic_io_trigger_filter_test;
  // per mode {start, stop} on falling, rising, low level, high level
  localparam logic [7:0] TBL [13] = '{8'h80, 8'h90, 8'h20, 8'h60, 8'h80, 8'h20, 8'h40, 8'h10, 8'h08, 8'h02, 8'h04, 8'h01, 8'h00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] want = 4'hF;
  logic [3:0] pins;
  logic [3:0] trig_mode = 4'h1;
  logic reciprocating_setting = 1'b1, dual_pump_setting = 1'b0, alarm = 1'b0, keypad_busy = 1'b0, event_armed = 1'b0;
  logic pumping = 1'b0, pause_timer_active = 1'b0, motor_option = 1'b0, program_active = 1'b0;
  logic dir_load = 1'b0, dir_load_value = 1'b0;
  logic start_req, stop_req, event_jump, prog_level, lockout_level, dir_infuse, dir_out, motor_out;
  wire logic trig_pin = pins[0], dir_pin = pins[1], event_pin = pins[2], prog_pin = pins[3];
  int fail_count = 0, cmp_count = 0, n_s = 0, n_p = 0, n_j = 0;
  ptf_trigger_top #(.SAMPLE_CYCLES(10)) i_dut (
    .clk(clk),
    .rst(rst),
    .trig_pin(trig_pin),
    .dir_pin(dir_pin),
    .event_pin(event_pin),
    .prog_pin(prog_pin),
    .trig_mode(trig_mode),
    .reciprocating_setting(reciprocating_setting),
    .dual_pump_setting(dual_pump_setting),
    .alarm(alarm),
    .keypad_busy(keypad_busy),
    .event_armed(event_armed),
    .pumping(pumping),
    .pause_timer_active(pause_timer_active),
    .motor_option(motor_option),
    .program_active(program_active),
    .dir_load(dir_load),
    .dir_load_value(dir_load_value),
    .start_req(start_req),
    .stop_req(stop_req),
    .event_jump(event_jump),
    .prog_level(prog_level),
    .lockout_level(lockout_level),
    .dir_infuse(dir_infuse),
    .dir_out(dir_out),
    .motor_out(motor_out)
  );
  ptf_switch_model #(.HOLD(30)) i_sw (.clk(clk), .want(want), .pins(pins));
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    n_s += start_req;
    n_p += stop_req;
    n_j += event_jump;
  end
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // level modes repeat while the old level drains, so only the settled window is judged
  task automatic step(input int i, input logic v, input logic [1:0] ea, input logic [1:0] eb, input bit la);
    @(negedge clk);
    // non-blocking so the switch model sees the new level on its next edge, not racing this one
    want[i] <= v;
    n_s = 0;
    n_p = 0;
    n_j = 0;
    repeat (50) @(negedge clk);
    if (!la)
      `CHK({n_s != 0, n_p != 0}, ea)
    n_s = 0;
    n_p = 0;
    repeat (30) @(negedge clk);
    `CHK({n_s != 0, n_p != 0}, eb)
  endtask : step
  task automatic pin(input int i, input logic v);
    step(i, v, 2'h0, 2'h0, 1'b0);
  endtask : pin
  task automatic t_reset();
    repeat (60) @(negedge clk);
    `CHK({n_s != 0, n_p != 0, dir_out}, 3'h1)
  endtask : t_reset
  task automatic t_modes();
    for (int m = 0; m < 13; m++)
    begin
      trig_mode = 4'(m);
      step(0, 1'b0, TBL[m][7:6], TBL[m][3:2], m > 7);
      step(0, 1'b1, TBL[m][5:4], TBL[m][1:0], m > 7);
    end
  endtask : t_modes
  task automatic t_toggle();
    trig_mode = 4'h0;
    program_active = 1'b1;
    step(0, 1'b0, 2'h1, 2'h0, 1'b0);
    trig_mode = 4'h2;
    step(0, 1'b1, 2'h1, 2'h0, 1'b0);
    program_active = 1'b0;
  endtask : t_toggle
  task automatic t_block();
    trig_mode = 4'h1;
    alarm = 1'b1;
    pin(0, 1'b0);
    alarm = 1'b0;
    keypad_busy = 1'b1;
    pin(0, 1'b1);
    keypad_busy = 1'b0;
    step(0, 1'b0, 2'h2, 2'h0, 1'b0);
    trig_mode = 4'hC;
  endtask : t_block
  task automatic t_dir();
    pin(1, 1'b0);
    `CHK(dir_out, 1'b1)
    pin(1, 1'b1);
    `CHK(dir_out, 1'b0)
    alarm = 1'b1;
    pin(1, 1'b0);
    `CHK(dir_out, 1'b0)
    alarm = 1'b0;
    pin(1, 1'b1);
    pin(1, 1'b0);
    `CHK(dir_out, 1'b1)
    dir_load = 1'b1;
    @(negedge clk);
    dir_load = 1'b0;
    @(negedge clk);
    `CHK({dir_infuse, dir_out}, 2'h0)
    reciprocating_setting = 1'b0;
    pin(1, 1'b1);
    `CHK(dir_out, 1'b0)
    dual_pump_setting = 1'b1;
    pin(1, 1'b0);
    `CHK(dir_out, 1'b0)
    pin(1, 1'b1);
    `CHK(dir_out, 1'b1)
    pin(1, 1'b0);
    `CHK(dir_out, 1'b0)
    dual_pump_setting = 1'b0;
  endtask : t_dir
  task automatic t_event();
    event_armed = 1'b1;
    pin(2, 1'b0);
    `CHK(n_j, 32'h1)
    pin(2, 1'b1);
    `CHK(n_j, 32'h0)
    event_armed = 1'b0;
    pin(2, 1'b0);
    `CHK(n_j, 32'h0)
  endtask : t_event
  task automatic t_prog();
    pin(3, 1'b0);
    `CHK({prog_level, lockout_level}, 2'h0)
    pin(3, 1'b1);
    `CHK({prog_level, lockout_level}, 2'h3)
  endtask : t_prog
  task automatic t_motor();
    for (int k = 0; k < 8; k++)
    begin
      {pumping, pause_timer_active, motor_option} = 3'(k);
      repeat (2) @(negedge clk);
      `CHK(motor_out, k[2] | k[1] & k[0])
    end
  endtask : t_motor
  // the tests need about 3800 cycles; this allows several times that
  initial
  begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_modes();
    t_toggle();
    t_block();
    t_dir();
    t_event();
    t_prog();
    t_motor();
    stop_test();
  end
endmodule : pump_logic_io_trigger_filter_test
bind ptf_trigger_top ptf_trigger_props i_props (
  .clk(clk),
  .rst(rst),
  .trig_mode(trig_mode),
  .alarm(alarm),
  .keypad_busy(keypad_busy),
  .dir_load(dir_load),
  .reciprocating_setting(reciprocating_setting),
  .dual_pump_setting(dual_pump_setting),
  .pumping(pumping),
  .pause_timer_active(pause_timer_active),
  .motor_option(motor_option),
  .start_req(start_req),
  .stop_req(stop_req),
  .prog_level(prog_level),
  .lockout_level(lockout_level),
  .dir_infuse(dir_infuse),
  .dir_out(dir_out),
  .motor_out(motor_out)
);
`default_nettype wire

// ===== src/ptf_filter_if.sv
// filtered levels and edges passed from the input filter to the decoder
`timescale 1ns/1ps
`default_nettype none
interface ptf_filter_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic valid;
  modport filt (output level, output rise, output fall, output valid);
  modport user (input level, input rise, input fall, input valid);
endinterface : ptf_filter_if
`default_nettype wire

// ===== src/ptf_input_filter.sv
// sampled debounce filter with edge detection for the control inputs
`timescale 1ns/1ps
`default_nettype none
module ptf_input_filter #(
  parameter int N = 4,
  parameter int SAMPLE_CYCLES = 6250000,
  parameter int STABLE_SAMPLES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] pins,
  ptf_filter_if.filt fo
);
  localparam int CW = $clog2(SAMPLE_CYCLES + 1);
  localparam int SW = $clog2(STABLE_SAMPLES + 1);
  logic [CW-1:0] div_r;
  logic tick;
  logic [N-1:0] cand_r;
  logic [N-1:0] level_r;
  logic [N-1:0] rise_r;
  logic [N-1:0] fall_r;
  logic valid_r;
  logic [SW-1:0] cnt_r [N];
  logic [N-1:0] accept;

  assign tick = (div_r == CW'(SAMPLE_CYCLES - 1));
  assign fo.level = level_r;
  assign fo.rise = rise_r;
  assign fo.fall = fall_r;
  assign fo.valid = valid_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_r <= '0;
    else
      div_r <= tick ? '0 : div_r + CW'(1);
  end

  // a level is accepted once it was seen on consecutive samples spanning the stable time
  always_comb
  begin
    for (int i = 0; i < N; i++)
      accept[i] = tick && (pins[i] == cand_r[i]) && (cnt_r[i] >= SW'(STABLE_SAMPLES - 1));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cand_r <= '0;
      level_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
      valid_r <= 1'b0;
      for (int i = 0; i < N; i++)
        cnt_r[i] <= '0;
    end
    else
    begin
      rise_r <= '0;
      fall_r <= '0;
      for (int i = 0; i < N; i++)
      begin
        if (tick)
        begin
          cand_r[i] <= pins[i];
          // shorter pulses restart the count and never reach the level
          if (pins[i] != cand_r[i])
            cnt_r[i] <= '0;
          else if (cnt_r[i] < SW'(STABLE_SAMPLES - 1))
            cnt_r[i] <= cnt_r[i] + SW'(1);
        end
        if (accept[i])
        begin
          level_r[i] <= pins[i];
          // first accepted level only loads, so power-up makes no edge
          rise_r[i] <= valid_r && !level_r[i] && pins[i];
          fall_r[i] <= valid_r && level_r[i] && !pins[i];
        end
      end
      if (tick && &accept)
        valid_r <= 1'b1;
    end
  end
endmodule : ptf_input_filter
`default_nettype wire

// ===== src/ptf_pkg.sv
// constants and types for the pump logic io trigger filter
package ptf_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SAMPLE_MS = 50;
  localparam int unsigned STABLE_MS = 100;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned STABLE_SAMPLES = STABLE_MS / SAMPLE_MS;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned IN_TRIG = 0;
  localparam int unsigned IN_DIR = 1;
  localparam int unsigned IN_EVENT = 2;
  localparam int unsigned IN_PROG = 3;
  localparam logic DIR_INFUSE = 1'b1;
  localparam logic DIR_RESET = 1'b1;
  typedef enum logic [3:0] {
    toggle_falling_mode,
    hold_to_run_mode,
    toggle_rising_mode,
    level_edge_mode,
    start_only_falling_mode,
    start_only_rising_mode,
    stop_only_falling_mode,
    stop_only_rising_mode,
    run_when_low_mode,
    run_when_high_mode,
    halt_when_low_mode,
    halt_when_high_mode,
    trigger_disabled_mode
  } ptf_trig_mode_e;
endpackage : ptf_pkg

// ===== src/ptf_trigger_top.sv
// pump rear logic io: input conditioning, trigger decode and status outputs
`timescale 1ns/1ps
`default_nettype none
module ptf_trigger_top #(
  parameter int SAMPLE_CYCLES = ptf_pkg::SAMPLE_CYCLES,
  parameter int STABLE_SAMPLES = ptf_pkg::STABLE_SAMPLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig_pin,
  input wire logic dir_pin,
  input wire logic event_pin,
  input wire logic prog_pin,
  input wire logic [3:0] trig_mode,
  input wire logic reciprocating_setting,
  input wire logic dual_pump_setting,
  input wire logic alarm,
  input wire logic keypad_busy,
  input wire logic event_armed,
  input wire logic pumping,
  input wire logic pause_timer_active,
  input wire logic motor_option,
  input wire logic program_active,
  input wire logic dir_load,
  input wire logic dir_load_value,
  output logic start_req,
  output logic stop_req,
  output logic event_jump,
  output logic prog_level,
  output logic lockout_level,
  output logic dir_infuse,
  output logic dir_out,
  output logic motor_out
);
  ptf_filter_if #(.N(ptf_pkg::NUM_INPUTS)) flt ();

  ptf_input_filter #(
    .N(ptf_pkg::NUM_INPUTS),
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .STABLE_SAMPLES(STABLE_SAMPLES)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .pins({prog_pin, event_pin, dir_pin, trig_pin}),
    .fo(flt)
  );

  logic start_req_r;
  logic stop_req_r;
  logic event_jump_r;
  logic prog_level_r;
  logic dir_r;
  logic dir_out_r;
  logic motor_r;

  // the normal and reversed variants differ only in which edge they react to
  function automatic logic pick_edge(input logic use_rise, input logic rise, input logic fall);
    pick_edge = use_rise ? rise : fall;
  endfunction : pick_edge

  // trigger and direction control is locked out while the keypad edits or an alarm stands
  wire ext_ok = !alarm && !keypad_busy;
  wire t_rise = flt.rise[ptf_pkg::IN_TRIG] && ext_ok;
  wire t_fall = flt.fall[ptf_pkg::IN_TRIG] && ext_ok;
  wire t_lvl = flt.level[ptf_pkg::IN_TRIG];
  wire lvl_ok = flt.valid && ext_ok;
  wire d_rise = flt.rise[ptf_pkg::IN_DIR] && ext_ok;
  wire d_fall = flt.fall[ptf_pkg::IN_DIR] && ext_ok;

  // toggle state follows the program's own run state, so a key stop is respected
  wire tog_edge_f = pick_edge(1'h0, t_rise, t_fall);
  wire tog_edge_r = pick_edge(1'h1, t_rise, t_fall);
  logic dec_start;
  logic dec_stop;

  always_comb
  begin
    dec_start = 1'b0;
    dec_stop = 1'b0;
    case (trig_mode)
      4'(ptf_pkg::toggle_falling_mode):
      begin
        dec_start = tog_edge_f && !program_active;
        dec_stop = tog_edge_f && program_active;
      end
      4'(ptf_pkg::toggle_rising_mode):
      begin
        dec_start = tog_edge_r && !program_active;
        dec_stop = tog_edge_r && program_active;
      end
      4'(ptf_pkg::hold_to_run_mode):
      begin
        dec_start = t_fall;
        dec_stop = t_rise;
      end
      4'(ptf_pkg::level_edge_mode):
      begin
        dec_start = t_rise;
        dec_stop = t_fall;
      end
      4'(ptf_pkg::start_only_falling_mode): dec_start = pick_edge(1'h0, t_rise, t_fall);
      4'(ptf_pkg::start_only_rising_mode): dec_start = pick_edge(1'h1, t_rise, t_fall);
      4'(ptf_pkg::stop_only_falling_mode): dec_stop = pick_edge(1'h0, t_rise, t_fall);
      4'(ptf_pkg::stop_only_rising_mode): dec_stop = pick_edge(1'h1, t_rise, t_fall);
      4'(ptf_pkg::run_when_low_mode): dec_start = lvl_ok && !t_lvl;
      4'(ptf_pkg::run_when_high_mode): dec_start = lvl_ok && t_lvl;
      4'(ptf_pkg::halt_when_low_mode): dec_stop = lvl_ok && !t_lvl;
      4'(ptf_pkg::halt_when_high_mode): dec_stop = lvl_ok && t_lvl;
      4'(ptf_pkg::trigger_disabled_mode):
      begin
        dec_start = 1'b0;
        dec_stop = 1'b0;
      end
      default:
      begin
        dec_start = 1'b0;
        dec_stop = 1'b0;
      end
    endcase
  end

  // reciprocating: fall goes to infuse, rise to withdraw; dual pump the opposite way
  wire rec_to_inf = reciprocating_setting && !dir_r && d_fall;
  wire rec_to_wdr = reciprocating_setting && dir_r && d_rise;
  wire dual_to_inf = dual_pump_setting && !reciprocating_setting && !dir_r && d_rise;
  wire dual_to_wdr = dual_pump_setting && !reciprocating_setting && dir_r && d_fall;
  wire dir_nxt = dir_load ? dir_load_value :
                 (rec_to_inf || dual_to_inf) ? ptf_pkg::DIR_INFUSE :
                 (rec_to_wdr || dual_to_wdr) ? !ptf_pkg::DIR_INFUSE : dir_r;
  wire motor_nxt = motor_option ? (pumping || pause_timer_active) : pumping;
  // the event input is gated only by the program's arming, not by alarms
  wire ev_nxt = event_armed && flt.fall[ptf_pkg::IN_EVENT];

  // edge-mode requests are single-cycle pulses; the sequencer takes them on the next edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      start_req_r <= 1'h0;
    else
      start_req_r <= dec_start;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stop_req_r <= 1'h0;
    else
      stop_req_r <= dec_stop;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      event_jump_r <= 1'h0;
    else
      event_jump_r <= ev_nxt;
  end

  // one flop keeps both program-input outputs straight from a register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prog_level_r <= 1'h0;
    else
      prog_level_r <= flt.level[ptf_pkg::IN_PROG];
  end

  // internal direction state that the reciprocating decode compares against
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dir_r <= ptf_pkg::DIR_RESET;
    else
      dir_r <= dir_nxt;
  end

  // separate pin flop so the direction pin never glitches through decode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dir_out_r <= ptf_pkg::DIR_RESET;
    else
      dir_out_r <= dir_nxt;
  end

  // the option only widens the high time to cover pause timers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      motor_r <= 1'h0;
    else
      motor_r <= motor_nxt;
  end

  assign start_req = start_req_r;
  assign stop_req = stop_req_r;
  assign event_jump = event_jump_r;
  assign prog_level = prog_level_r;
  assign lockout_level = prog_level_r;
  assign dir_infuse = dir_r;
  assign dir_out = dir_out_r;
  assign motor_out = motor_r;
endmodule : ptf_trigger_top
`default_nettype wire
